//--- rtl/irht_pkg.sv
// Shared constants for the input re-validation and hold-off timing block
package irht_pkg;
    // ****************************************************************
    // Field widths
    // ****************************************************************
    localparam int INPUTS      = 2;
    localparam int DIV_CODE_W  = 2;
    localparam int REVAL_W     = 7;
    localparam int HOLDOFF_W   = 8;
    localparam int PRESCALE_W  = 17;

    // ****************************************************************
    // Register reset values
    // ****************************************************************
    localparam logic [DIV_CODE_W-1:0] TICK_DIV_RESET  = 2'h2;
    localparam logic [DIV_CODE_W-1:0] REVAL_SEL_RESET = 2'h2;
    localparam logic [HOLDOFF_W-1:0]  HOLDOFF_RESET   = 8'h80;

    // ****************************************************************
    // Hold-off tick divider codes
    // ****************************************************************
    localparam logic [DIV_CODE_W-1:0] TICK_DIV_2P15 = 2'h0;
    localparam logic [DIV_CODE_W-1:0] TICK_DIV_2P16 = 2'h1;
    localparam logic [DIV_CODE_W-1:0] TICK_DIV_2P17 = 2'h2;
    localparam logic [DIV_CODE_W-1:0] TICK_DIV_RSVD = 2'h3;

    // ****************************************************************
    // Re-validation period counts
    // ****************************************************************
    localparam logic [DIV_CODE_W-1:0] REVAL_SEL_2  = 2'h0;
    localparam logic [DIV_CODE_W-1:0] REVAL_SEL_16 = 2'h1;
    localparam logic [DIV_CODE_W-1:0] REVAL_SEL_32 = 2'h2;
    localparam logic [REVAL_W-1:0]    REVAL_CNT_2  = 7'h02;
    localparam logic [REVAL_W-1:0]    REVAL_CNT_16 = 7'h10;
    localparam logic [REVAL_W-1:0]    REVAL_CNT_32 = 7'h20;
    localparam logic [REVAL_W-1:0]    REVAL_CNT_64 = 7'h40;

    // Clock cycles without an input edge that count as a missing period
    localparam int GAP_CYCLES_DEFAULT = 64;

    function automatic logic [REVAL_W-1:0] irht_reval_count(input logic [DIV_CODE_W-1:0] sel);
        if (sel == REVAL_SEL_2) begin
            return REVAL_CNT_2;
        end else if (sel == REVAL_SEL_16) begin
            return REVAL_CNT_16;
        end else if (sel == REVAL_SEL_32) begin
            return REVAL_CNT_32;
        end
        return REVAL_CNT_64;
    endfunction : irht_reval_count
endpackage : irht_pkg

//--- rtl/irht_reval_counter.sv
// Per-input re-validation counter and loss flag
`timescale 1ns/1ps
module irht_reval_counter
    import irht_pkg::*;
#(
    parameter int GAP_CYCLES = GAP_CYCLES_DEFAULT
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               input_edge,
    input  wire logic               los_event,
    input  wire logic [REVAL_W-1:0] reload_value,
    output logic      [REVAL_W-1:0] count,
    output logic                    loss_of_signal_flag,
    output logic                    revalidated
);
    localparam int GAP_W = $clog2(GAP_CYCLES + 1);
    localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYCLES - 1);
    localparam logic [REVAL_W-1:0] CNT_ONE = 7'h01;
    localparam logic [REVAL_W-1:0] CNT_ZERO = 7'h00;

    logic [GAP_W-1:0] gap_count;
    logic             missing;
    logic             last_period;

    // ****************************************************************
    // Missing-edge detection
    // ****************************************************************
    assign missing     = loss_of_signal_flag && !input_edge && (gap_count == GAP_LAST);
    assign last_period = loss_of_signal_flag && input_edge && (count == CNT_ONE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_count <= '0;
        end else if (input_edge || los_event || missing) begin
            gap_count <= '0;
        end else if (gap_count != GAP_LAST) begin
            gap_count <= gap_count + 1'b1;
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= CNT_ZERO;
        end else if (los_event) begin
            count <= reload_value;
        end else if (missing) begin
            count <= reload_value;
        end else if (loss_of_signal_flag && input_edge && count != CNT_ZERO) begin
            count <= count - 1'b1;
        end
    end

    // A new loss event wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loss_of_signal_flag <= 1'b0;
            revalidated         <= 1'b0;
        end else begin
            revalidated <= last_period && !los_event;
            if (los_event) begin
                loss_of_signal_flag <= 1'b1;
            end else if (last_period) begin
                loss_of_signal_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    los_load_a: assert property (@(posedge clock) disable iff (rst)
        los_event |=> (count == $past(reload_value)) && loss_of_signal_flag)
        else $error("counter not loaded on loss event");

    sequence valid_step_s;
        loss_of_signal_flag && input_edge && !los_event && count > CNT_ONE;
    endsequence

    dec_edge_a: assert property (@(posedge clock) disable iff (rst)
        valid_step_s |=> count == $past(count) - 1'b1)
        else $error("counter did not step down by one");

    reval_pulse_a: assert property (@(posedge clock) disable iff (rst)
        revalidated |=> !revalidated)
        else $error("re-validated pulse longer than one cycle");

    gap_reload_a: assert property (@(posedge clock) disable iff (rst)
        (missing && !los_event) |=> count == $past(reload_value))
        else $error("missing edge did not reload counter");

    flag_clear_a: assert property (@(posedge clock) disable iff (rst)
        (last_period && !los_event) |=> !loss_of_signal_flag && revalidated && count == CNT_ZERO)
        else $error("flag not cleared at zero transition");
endmodule : irht_reval_counter

//--- rtl/irht_holdoff_timing.sv
// Hold-off tick prescaler, hold-off counter and re-validation for two inputs
`timescale 1ns/1ps
// What this block does
// - The hold-off tick is the clock divided by 2^15, 2^16 or 2^17 for divider codes 00, 01, 10.
// - The re-validation period count is 2, 16, 32 or 64 for select codes 00, 01, 10, 11.
// - A loss-of-signal event loads that input's re-validation counter with the programmed count.
// - Each valid consecutive input period steps the re-validation counter down by one.
// - A missing input edge during re-validation reloads the counter and restarts the count.
// - When the counter reaches zero the input is re-validated and its loss flag is cleared.
// - After a loss event the 8-bit hold-off counter counts ticks, switches over at zero, reloads.
module irht_holdoff_timing
    import irht_pkg::*;
#(
    parameter int TICK_EXP_00 = 15,
    parameter int TICK_EXP_01 = 16,
    parameter int TICK_EXP_10 = 17,
    parameter int GAP_CYCLES  = GAP_CYCLES_DEFAULT
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [INPUTS-1:0]       ref_clk_in,
    input  wire logic [INPUTS-1:0]       los_event,
    input  wire logic                    cfg_write,
    input  wire logic [DIV_CODE_W-1:0]   cfg_tick_div,
    input  wire logic [DIV_CODE_W-1:0]   cfg_reval_sel,
    input  wire logic [HOLDOFF_W-1:0]    cfg_holdoff_count,
    output logic      [DIV_CODE_W-1:0]   holdoff_tick_divider,
    output logic      [DIV_CODE_W-1:0]   revalidation_count_select,
    output logic      [HOLDOFF_W-1:0]    holdoff_period_count,
    output logic      [INPUTS-1:0]       loss_of_signal_flag,
    output logic      [INPUTS-1:0]       revalidated,
    output logic [INPUTS-1:0][REVAL_W-1:0] reval_count,
    output logic                         holdoff_tick,
    output logic      [HOLDOFF_W-1:0]    holdoff_count,
    output logic                         failover_switch,
    output logic                         tick_div_reserved
);
    localparam logic [HOLDOFF_W-1:0] HOLD_ONE = 8'h01;
    // Two ticks under one divider setting before their spacing is trusted
    localparam logic [1:0]           TICK_SETTLED = 2'h2;

    logic [PRESCALE_W-1:0] prescale;
    logic [INPUTS-1:0]     ref_meta;
    logic [INPUTS-1:0]     ref_sync;
    logic [INPUTS-1:0]     ref_prev;
    logic [INPUTS-1:0]     ref_edge;
    logic                  tick_wrap;
    logic                  holdoff_active;
    logic [PRESCALE_W-1:0] tick_since;
    logic [1:0]            tick_seen;

    function automatic logic [PRESCALE_W-1:0] tick_mask(input logic [DIV_CODE_W-1:0] code);
        if (code == TICK_DIV_2P15) begin
            return PRESCALE_W'((64'h1 << TICK_EXP_00) - 64'h1);
        end else if (code == TICK_DIV_2P16) begin
            return PRESCALE_W'((64'h1 << TICK_EXP_01) - 64'h1);
        end
        return PRESCALE_W'((64'h1 << TICK_EXP_10) - 64'h1);
    endfunction : tick_mask

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            holdoff_tick_divider      <= TICK_DIV_RESET;
            revalidation_count_select <= REVAL_SEL_RESET;
            holdoff_period_count      <= HOLDOFF_RESET;
        end else if (cfg_write) begin
            holdoff_tick_divider      <= cfg_tick_div;
            revalidation_count_select <= cfg_reval_sel;
            holdoff_period_count      <= cfg_holdoff_count;
        end
    end

    assign tick_div_reserved = (holdoff_tick_divider == TICK_DIV_RSVD);

    // ****************************************************************
    // Hold-off tick prescaler
    // ****************************************************************
    // Free-running so a divider change takes effect at the next boundary
    assign tick_wrap = ((prescale & tick_mask(holdoff_tick_divider))
                       == tick_mask(holdoff_tick_divider)) && !tick_div_reserved;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale     <= '0;
            holdoff_tick <= 1'b0;
        end else begin
            prescale     <= prescale + 1'b1;
            holdoff_tick <= tick_wrap;
        end
    end

    // ****************************************************************
    // Hold-off counter
    // ****************************************************************
    assign holdoff_active = |loss_of_signal_flag;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            holdoff_count   <= HOLDOFF_RESET;
            failover_switch <= 1'b0;
        end else begin
            failover_switch <= 1'b0;
            if (|los_event) begin
                holdoff_count <= holdoff_period_count;
            end else if (holdoff_active && holdoff_tick) begin
                if (holdoff_count <= HOLD_ONE) begin
                    failover_switch <= 1'b1;
                    holdoff_count   <= holdoff_period_count;
                end else begin
                    holdoff_count <= holdoff_count - 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Reference input synchronisers and re-validation
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_meta <= '0;
            ref_sync <= '0;
            ref_prev <= '0;
        end else begin
            ref_meta <= ref_clk_in;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
        end
    end

    assign ref_edge = ref_sync & ~ref_prev;

    for (genvar i = 0; i < INPUTS; i++) begin : g_reval
        irht_reval_counter #(
            .GAP_CYCLES (GAP_CYCLES)
        ) u_reval (
            .clock               (clock),
            .rst                 (rst),
            .input_edge          (ref_edge[i]),
            .los_event           (los_event[i]),
            .reload_value        (irht_reval_count(revalidation_count_select)),
            .count               (reval_count[i]),
            .loss_of_signal_flag (loss_of_signal_flag[i]),
            .revalidated         (revalidated[i])
        );
    end

    // ****************************************************************
    // Tick spacing monitor
    // ****************************************************************
    // A divider write makes one odd gap, so only settled ticks are measured
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_since <= '0;
            tick_seen  <= '0;
        end else begin
            if (holdoff_tick) begin
                tick_since <= '0;
            end else begin
                tick_since <= tick_since + 1'b1;
            end
            if (cfg_write) begin
                tick_seen <= '0;
            end else if (holdoff_tick && tick_seen != TICK_SETTLED) begin
                tick_seen <= tick_seen + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    tick_space_a: assert property (@(posedge clock) disable iff (rst)
        (holdoff_tick && tick_seen == TICK_SETTLED) |->
        tick_since == tick_mask(holdoff_tick_divider))
        else $error("hold-off tick spacing does not match divider");

    cfg_load_a: assert property (@(posedge clock) disable iff (rst)
        cfg_write |=> holdoff_tick_divider == $past(cfg_tick_div)
        && revalidation_count_select == $past(cfg_reval_sel))
        else $error("configuration write not taken");

    reval_setting_a: assert property (@(posedge clock) disable iff (rst)
        (los_event[0] && !cfg_write) |=>
        reval_count[0] == irht_reval_count(revalidation_count_select))
        else $error("re-validation count does not match setting");

    reserved_no_tick_a: assert property (@(posedge clock) disable iff (rst)
        tick_div_reserved[*2] |-> !holdoff_tick)
        else $error("tick produced with reserved divider");

    tick_pulse_a: assert property (@(posedge clock) disable iff (rst)
        holdoff_tick |=> !holdoff_tick)
        else $error("hold-off tick longer than one cycle");

    sequence expire_s;
        holdoff_active && holdoff_tick && !(|los_event) && holdoff_count <= HOLD_ONE;
    endsequence

    failover_reload_a: assert property (@(posedge clock) disable iff (rst)
        expire_s |=> failover_switch && holdoff_count == $past(holdoff_period_count))
        else $error("no failover at hold-off expiry");

    holdoff_step_a: assert property (@(posedge clock) disable iff (rst)
        (holdoff_active && holdoff_tick && !(|los_event) && holdoff_count > HOLD_ONE)
        |=> !failover_switch && holdoff_count == $past(holdoff_count) - 1'b1)
        else $error("hold-off counter did not step");

    holdoff_load_a: assert property (@(posedge clock) disable iff (rst)
        (|los_event) |=> holdoff_count == $past(holdoff_period_count))
        else $error("hold-off counter not loaded on loss event");

    failover_pulse_a: assert property (@(posedge clock) disable iff (rst)
        failover_switch |=> !failover_switch)
        else $error("failover switch longer than one cycle");

    holdoff_idle_a: assert property (@(posedge clock) disable iff (rst)
        (!holdoff_active && !(|los_event)) |=> !failover_switch && $stable(holdoff_count))
        else $error("hold-off counter moved with no loss flag set");

    edge_sync_a: assert property (@(posedge clock) disable iff (rst)
        ref_edge[0] |-> $past(ref_clk_in[0], 2) && !$past(ref_clk_in[0], 3))
        else $error("input edge not taken through two flip-flops");
endmodule : irht_holdoff_timing

//--- testbench/irht_ref_source.sv
// Behavioural reference clock source feeding one input pin
`timescale 1ns/1ps
module irht_ref_source #(
    parameter int HALF = 40
) (
    input  wire logic       run,
    output logic            clk_out,
    output logic [7:0]      edges
);
    initial begin
        clk_out = 1'b0;
        edges   = 8'h00;
    end
    // A stopped source parks low, as a lost reference does; a stop lands after the open period
    always begin
        if (run !== 1'b1) begin
            clk_out = 1'b0;
            @(posedge run);
            // Offset keeps pin edges off the sampling clock edge
            #3;
            edges = 8'h00;
        end
        #(HALF) clk_out = 1'b1;
        edges = edges + 8'h01;
        #(HALF) clk_out = 1'b0;
    end
endmodule : irht_ref_source

//--- testbench/input_revalidation_holdoff_timing_test.sv
// Self-checking testbench for input re-validation and hold-off timing
`timescale 1ns/1ps
module input_revalidation_holdoff_timing_test
    import irht_pkg::*;
;
    localparam int GAP     = 16;
    localparam int EXP [3] = '{3, 4, 5};
    localparam int CNT [4] = '{2, 16, 32, 64};
    logic                          clock = 1'b0;
    logic                          rst = 1'b1;
    logic [INPUTS-1:0]             ref_clk_in, los_event, run, revalidated, loss_of_signal_flag;
    logic                          cfg_write, holdoff_tick, failover_switch, tick_div_reserved;
    logic [DIV_CODE_W-1:0]         cfg_tick_div, cfg_reval_sel;
    logic [DIV_CODE_W-1:0]         holdoff_tick_divider, revalidation_count_select, prev_div;
    logic [HOLDOFF_W-1:0]          cfg_holdoff_count, holdoff_period_count, holdoff_count;
    logic [INPUTS-1:0][REVAL_W-1:0] reval_count;
    logic [7:0]                    edges [2];
    logic [7:0]                    seed;
    int                            err_total = 0, total_checks = 0, cyc = 0, last_tick, ticks, n;
    int                            last_cfg = 0;
    bit                            tick_ok;
    int                            reval_q [$], fail_q [$];

    always #4 clock = ~clock;

    irht_holdoff_timing #(.TICK_EXP_00(3), .TICK_EXP_01(4), .TICK_EXP_10(5), .GAP_CYCLES(GAP))
    dut_u (.clock, .rst, .ref_clk_in, .los_event, .cfg_write, .cfg_tick_div, .cfg_reval_sel,
        .cfg_holdoff_count, .holdoff_tick_divider, .revalidation_count_select,
        .holdoff_period_count, .loss_of_signal_flag, .revalidated, .reval_count,
        .holdoff_tick, .holdoff_count, .failover_switch, .tick_div_reserved);
    irht_ref_source src0_u (.run(run[0]), .clk_out(ref_clk_in[0]), .edges(edges[0]));
    irht_ref_source src1_u (.run(run[1]), .clk_out(ref_clk_in[1]), .edges(edges[1]));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic cfg(logic [1:0] td, logic [1:0] rs, logic [7:0] hc);
        @(posedge clock);
        cfg_write <= 1'b1;
        cfg_tick_div <= td;
        cfg_reval_sel <= rs;
        cfg_holdoff_count <= hc;
        @(posedge clock);
        cfg_write <= 1'b0;
        #1;
        check("tick_div", holdoff_tick_divider, td);
        check("reval_sel", revalidation_count_select, rs);
        check("period_count", holdoff_period_count, hc);
        check("rsvd_flag", tick_div_reserved, td == TICK_DIV_RSVD);
    endtask : cfg

    // Stop a source, let its last edge drain, then pulse its loss event
    task automatic lose(int i);
        @(posedge clock);
        run[i] <= 1'b0;
        repeat (24) @(posedge clock);
        los_event[i] <= 1'b1;
        @(posedge clock);
        los_event <= '0;
        #1;
        check("flag_set", loss_of_signal_flag[i], 1);
    endtask : lose

    task automatic start(int i);
        @(posedge clock);
        run[i] <= 1'b1;
    endtask : start

    task automatic wait_done();
        for (int k = 0; k < 5000 && (reval_q.size() + fail_q.size()) > 0; k++) begin
            @(posedge clock);
        end
        if ((reval_q.size() + fail_q.size()) > 0) begin
            check("timeout", 1, 0);
            end_of_test();
        end
    endtask : wait_done

    // ****************************************************************
    // Output watcher: takes the oldest note whenever an event shows
    // ****************************************************************
    always @(posedge clock) begin
        cyc++;
        // A tick shows one cycle after the divider setting that made it
        if (cfg_write === 1'b1) last_cfg = cyc;
        if (holdoff_tick === 1'b1) begin
            if (prev_div === TICK_DIV_RSVD) check("rsvd_tick", 1, 0);
            else if (tick_ok && last_tick >= last_cfg + 2)
                check("tick_gap", cyc - last_tick, 1 << EXP[prev_div]);
            last_tick = cyc;
            tick_ok = 1;
            if (|loss_of_signal_flag) ticks++;
        end
        if (|los_event) ticks = 0;
        if (failover_switch === 1'b1) begin
            if (fail_q.size() == 0) check("extra_failover", 1, 0);
            else check("ticks_to_failover", ticks, fail_q.pop_front());
            ticks = 0;
        end
        if (|revalidated) begin
            if (reval_q.size() == 0) check("extra_reval", 1, 0);
            else begin
                n = reval_q.pop_front();
                check("reval_input", revalidated, 1 << (n >> 8));
                check("reval_periods", edges[n >> 8], n & 255);
                check("flag_clear", loss_of_signal_flag[n >> 8], 0);
            end
        end
        prev_div = holdoff_tick_divider;
    end

    initial begin
        int i;
        int hc;
        {run, los_event, cfg_write, cfg_tick_div, cfg_reval_sel, cfg_holdoff_count} = '0;
        seed = 8'h5C;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        check("rst_tick_div", holdoff_tick_divider, TICK_DIV_RESET);
        check("rst_reval_sel", revalidation_count_select, REVAL_SEL_RESET);
        check("rst_period", holdoff_period_count, HOLDOFF_RESET);
        check("rst_holdoff", holdoff_count, HOLDOFF_RESET);
        check("rst_flags", loss_of_signal_flag, 0);
        $display("TEST reset done");
        for (int c = 0; c < 4; c++) begin
            seed = lfsr(seed);
            i = seed[0];
            cfg(TICK_DIV_RSVD, c[1:0], seed);
            lose(i);
            check("reval_load", reval_count[i], CNT[c]);
            reval_q.push_back(i * 256 + CNT[c]);
            start(i);
            wait_done();
        end
        $display("TEST revalidation codes done");
        cfg(TICK_DIV_RSVD, REVAL_SEL_16, 8'h10);
        lose(0);
        start(0);
        repeat (52) @(posedge clock);
        #1;
        check("reval_step", reval_count[0], 11);
        run[0] <= 1'b0;
        repeat (40) @(posedge clock);
        #1;
        check("reval_reload", reval_count[0], 16);
        reval_q.push_back(16);
        start(0);
        wait_done();
        $display("TEST missing edge done");
        for (int c = 0; c < 3; c++) begin
            seed = lfsr(seed);
            hc = 2 + seed[1:0];
            cfg(c[1:0], REVAL_SEL_2, hc[7:0]);
            fail_q.push_back(hc);
            fail_q.push_back(hc);
            lose(0);
            check("holdoff_load", holdoff_count, hc);
            wait_done();
            // Stop the ticks first so no further switch-over races the re-validation
            cfg(TICK_DIV_RSVD, REVAL_SEL_2, hc[7:0]);
            reval_q.push_back(2);
            start(0);
            wait_done();
        end
        $display("TEST hold-off done");
        end_of_test();
    end
endmodule : input_revalidation_holdoff_timing_test
